// >>> buck_fault_protection_sequencer.sv
// protection, discharge, window flag and light-load sequencer of a step-down converter
// Functional notes
// - valley current above limit keeps low side on and blocks next high pulse
// - feedback under 80 percent for 64 us latches both switches off
// - undervoltage detector and timer idle until soft start completes
// - feedback back above threshold clears the undervoltage timer to zero
// - after latch-off both switches stay off until enable toggles or supply resets; an over-temperature event also releases the latch here
// - current limiting during start-up trips undervoltage latch when soft start ends
// - low limit-set resistor selects the fixed internal current clamp
// - negative limit in low phase: low off, one high on-time, low on
// - window flag goes high only after soft start with output in window
// - feedback out of window for 5 us latches the window flag low
// - latched-low window flag stays low until enable toggles or supply resets
// - overvoltage latches high side off, cycles low side against negative limit
// - soft overvoltage forces continuous conduction with low-side discharge, no latch
// - discharge mode: switches off, discharge on, both off below 100 mV
// - enable low, over-temperature or either supply lockout enters discharge
// - discharge switch stays on 128 us after all triggers clear
// - control supply lockout shuts off and recovers without latching
// - input supply lockout stops switching, discharges soft start, restarts fresh
// - over-temperature stops switching, discharges soft start, restarts fresh
// - skip mode: low off at zero cross, 16 in a row enter light load
// - pre-biased output above command during soft start skips pulses
// - mode input sampled once in calibration window, later changes ignored
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "buck_seq_consts.svh"

module buck_fault_protection_sequencer
    import buck_seq_pkg::*;
#(
    parameter int unsigned DIS_HOLD_CYC = `DIS_HOLD_CYC,
    parameter int unsigned CAL_CYC = `CAL_CYC
)(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // enable pin and supply monitors
    input wire logic enable_pin,
    input wire logic vcc_ok,
    input wire logic vin_ok,
    input wire logic over_temp,
    // feedback comparators
    input wire logic undervoltage_guard_hit,
    input wire logic overvoltage_guard_hit,
    input wire logic soft_overvoltage_clamp_hit,
    input wire logic feedback_sense_below_100mv,
    // current comparators
    input wire logic valley_current_limit_hit,
    input wire logic negative_current_limit_hit,
    input wire logic zero_cross_threshold_hit,
    // loop and start-up status
    input wire logic ss_complete,
    input wire logic prebias_above_command,
    input wire logic ontime_done,
    input wire logic hs_request,
    // straps
    input wire logic limit_set_pin_low,
    input wire logic mode_skip_sel,
    input wire logic [1:0] mode_freq_sel,
    // power stage controls
    output logic hs_enable,
    output logic ls_enable,
    output logic discharge_on,
    output logic ss_discharge,
    output logic regulator_on,
    output logic fixed_clamp_sel,
    output logic light_load_mode,
    output logic [1:0] freq_sel,
    // open-drain window flag
    output logic output_in_window_flag_out,
    output logic output_in_window_flag_oe
);
    localparam int UNDER_CYC = `UNDER_DELAY_CYC;
    localparam int WIN_CYC = `WIN_DELAY_CYC;
    localparam int ZERO_N = `ZERO_ENTRY_COUNT;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    logic [`IN_COUNT-1:0] in_raw;
    logic [`IN_COUNT-1:0] meta_reg;
    logic [`IN_COUNT-1:0] sync_reg;
    logic zero_prev_reg;
    logic neg_prev_reg;
    logic ontime_prev_reg;
    seq_state_t state_reg;
    logic ctrl_en_reg;
    logic [31:0] prdata_reg;
    logic [15:0] under_cnt_reg;
    logic [15:0] win_cnt_reg;
    logic [15:0] dis_cnt_reg;
    logic [15:0] cal_cnt_reg;
    logic cal_done_reg;
    logic skip_mode_reg;
    logic [1:0] freq_sel_reg;
    logic clamp_reg;
    logic ocl_seen_reg;
    logic over_latch_reg;
    logic low100_reg;
    logic discharge_on_reg;
    logic ss_dis_reg;
    logic hs_on_reg;
    logic ls_on_reg;
    logic [4:0] zero_cnt_reg;
    logic zero_seen_reg;
    logic light_reg;
    logic win_latch_reg;
    logic win_low_reg;

    assign in_raw = {mode_freq_sel, mode_skip_sel, limit_set_pin_low, hs_request,
                     ontime_done, prebias_above_command, ss_complete,
                     zero_cross_threshold_hit, negative_current_limit_hit,
                     valley_current_limit_hit, feedback_sense_below_100mv,
                     soft_overvoltage_clamp_hit, overvoltage_guard_hit,
                     undervoltage_guard_hit, over_temp, vin_ok, vcc_ok, enable_pin};

    genvar gi;
    generate
        for (gi = 0; gi < `IN_COUNT; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys)
            begin
                if (!reset_n)
                begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end
                else
                begin
                    meta_reg[gi] <= in_raw[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    logic en_s, under_s, over_s, valley_s, trig, active;
    logic zero_rise, neg_rise, ontime_rise, hs_start, under_expire, win_bad;
    assign en_s = sync_reg[`IN_EN] & ctrl_en_reg;
    assign under_s = sync_reg[`IN_UNDER];
    assign over_s = sync_reg[`IN_OVER];
    assign valley_s = sync_reg[`IN_VALLEY];
    // any lockout, heat limit or disable leads into discharge
    assign trig = !en_s | sync_reg[`IN_OVER_TEMP] | !sync_reg[`IN_VCC_OK] | !sync_reg[`IN_VIN_OK];
    assign active = (state_reg == ST_SOFTSTART) || (state_reg == ST_RUN);
    assign zero_rise = sync_reg[`IN_ZERO] & !zero_prev_reg;
    assign neg_rise = sync_reg[`IN_NEG] & !neg_prev_reg;
    assign ontime_rise = sync_reg[`IN_ONTIME] & !ontime_prev_reg;
    // detector only armed in run, after soft start
    assign under_expire = (state_reg == ST_RUN) && under_s &&
                          (under_cnt_reg == 16'(UNDER_CYC - 1));
    // pulse start: negative limit forces one on-time, else loop request gated
    assign hs_start = active && !hs_on_reg &&
                      ((ls_on_reg && neg_rise) ||
                       (sync_reg[`IN_HS_REQ] && !valley_s && !over_latch_reg &&
                        !((state_reg == ST_SOFTSTART) && sync_reg[`IN_PREBIAS])));
    assign win_bad = (state_reg == ST_RUN) && (under_s || over_s);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            zero_prev_reg <= 1'b0;
            neg_prev_reg <= 1'b0;
            ontime_prev_reg <= 1'b0;
        end
        else
        begin
            zero_prev_reg <= sync_reg[`IN_ZERO];
            neg_prev_reg <= sync_reg[`IN_NEG];
            ontime_prev_reg <= sync_reg[`IN_ONTIME];
        end
    end

    // mode strap latched once; the window closes for good after calibration
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cal_cnt_reg <= 16'h0000;
            cal_done_reg <= 1'b0;
            skip_mode_reg <= 1'b0;
            freq_sel_reg <= 2'h0;
        end
        else if (!cal_done_reg)
        begin
            cal_cnt_reg <= cal_cnt_reg + 16'h0001;
            if (cal_cnt_reg == 16'(CAL_CYC - 1))
            begin
                cal_done_reg <= 1'b1;
                skip_mode_reg <= sync_reg[`IN_MODE_SKIP];
                freq_sel_reg <= sync_reg[`IN_FREQ_LSB +: 2];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            clamp_reg <= 1'b0;
        else
            clamp_reg <= sync_reg[`IN_LIMIT_LOW];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            state_reg <= ST_OFF;
        else
        begin
            unique case (state_reg)
                ST_OFF:
                    if (cal_done_reg)
                        state_reg <= trig ? ST_DISCHARGE : ST_SOFTSTART;
                ST_DISCHARGE:
                    if (!trig && dis_cnt_reg == 16'(DIS_HOLD_CYC - 1))
                        state_reg <= ST_SOFTSTART;
                ST_SOFTSTART:
                    if (trig)
                        state_reg <= ST_DISCHARGE;
                    else if (sync_reg[`IN_SS_DONE])
                        state_reg <= ocl_seen_reg ? ST_LATCHED : ST_RUN;
                ST_RUN:
                    if (trig)
                        state_reg <= ST_DISCHARGE;
                    else if (under_expire)
                        state_reg <= ST_LATCHED;
                ST_LATCHED:
                    if (trig)
                        state_reg <= ST_DISCHARGE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || state_reg != ST_RUN || !under_s)
            under_cnt_reg <= 16'h0000;
        else
            under_cnt_reg <= under_cnt_reg + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !active)
            ocl_seen_reg <= 1'b0;
        else if (state_reg == ST_SOFTSTART && valley_s)
            ocl_seen_reg <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !active)
            over_latch_reg <= 1'b0;
        else if (state_reg == ST_RUN && over_s)
            over_latch_reg <= 1'b1;
    end

    // hold counter restarts whenever any trigger reappears
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || state_reg != ST_DISCHARGE || trig)
            dis_cnt_reg <= 16'h0000;
        else
            dis_cnt_reg <= dis_cnt_reg + 16'h0001;
    end

    // the 100 mV cut stays until discharge is left, so the regulator is not re-powered
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || state_reg != ST_DISCHARGE)
            low100_reg <= 1'b0;
        else if (sync_reg[`IN_BELOW_100MV])
            low100_reg <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            discharge_on_reg <= 1'b0;
            ss_dis_reg <= 1'b1;
        end
        else
        begin
            discharge_on_reg <= (state_reg == ST_DISCHARGE) && !low100_reg;
            ss_dis_reg <= !active;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !active)
            hs_on_reg <= 1'b0;
        else if (state_reg == ST_RUN && over_s && !over_latch_reg)
            hs_on_reg <= 1'b0;
        else if (hs_start)
            hs_on_reg <= 1'b1;
        else if (ontime_rise)
            hs_on_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !active)
            ls_on_reg <= 1'b0;
        else if (state_reg == ST_RUN && over_s && !over_latch_reg)
            ls_on_reg <= 1'b1;
        else if (hs_start)
            ls_on_reg <= 1'b0;
        else if (hs_on_reg && ontime_rise)
            ls_on_reg <= 1'b1;
        else if (sync_reg[`IN_SOFT_OVER] && !hs_on_reg)
            ls_on_reg <= 1'b1;
        else if (ls_on_reg && zero_rise && skip_mode_reg && !over_latch_reg && !valley_s)
            ls_on_reg <= 1'b0;
    end

    // a pulse with no zero cross in the low phase before it breaks the run of crossings
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !active || !skip_mode_reg || sync_reg[`IN_SOFT_OVER])
        begin
            zero_cnt_reg <= 5'h00;
            zero_seen_reg <= 1'b0;
            light_reg <= 1'b0;
        end
        else if (ls_on_reg && zero_rise)
        begin
            zero_seen_reg <= 1'b1;
            if (zero_cnt_reg != 5'(ZERO_N))
                zero_cnt_reg <= zero_cnt_reg + 5'h01;
            if (zero_cnt_reg == 5'(ZERO_N - 1))
                light_reg <= 1'b1;
        end
        else if (hs_start)
        begin
            zero_seen_reg <= 1'b0;
            if (!zero_seen_reg)
            begin
                zero_cnt_reg <= 5'h00;
                light_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !win_bad || win_latch_reg)
            win_cnt_reg <= 16'h0000;
        else
            win_cnt_reg <= win_cnt_reg + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !en_s || !sync_reg[`IN_VCC_OK])
            win_latch_reg <= 1'b0;
        else if (win_bad && win_cnt_reg == 16'(WIN_CYC - 1))
            win_latch_reg <= 1'b1;
    end

    // a short excursion does not drop the flag; only the qualified latch does
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            win_low_reg <= 1'b1;
        else if (state_reg != ST_RUN || win_latch_reg)
            win_low_reg <= 1'b1;
        else if (!under_s && !over_s)
            win_low_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            ctrl_en_reg <= `CTRL_EN_RESET;
        else if (psel && penable && pwrite && addr_is(paddr, `ADDR_CTRL))
            ctrl_en_reg <= pwdata[`CTRL_EN_BIT];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            prdata_reg <= 32'h0000_0000;
            if (addr_is(paddr, `ADDR_CTRL))
                prdata_reg[0] <= ctrl_en_reg;
            else if (addr_is(paddr, `ADDR_STATUS))
                prdata_reg[9:0] <= {win_latch_reg, over_latch_reg, discharge_on_reg,
                                    light_reg, !win_low_reg,
                                    state_reg == ST_LATCHED, 1'b0, 3'(state_reg)};
            else if (addr_is(paddr, `ADDR_CONFIG))
                prdata_reg[4:0] <= {cal_done_reg, clamp_reg, freq_sel_reg, skip_mode_reg};
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_is(paddr, `ADDR_CTRL) &&
                     !addr_is(paddr, `ADDR_STATUS) && !addr_is(paddr, `ADDR_CONFIG);
    assign hs_enable = hs_on_reg;
    assign ls_enable = ls_on_reg;
    assign discharge_on = discharge_on_reg;
    assign ss_discharge = ss_dis_reg;
    assign regulator_on = !low100_reg;
    assign fixed_clamp_sel = clamp_reg;
    assign light_load_mode = light_reg;
    assign freq_sel = freq_sel_reg;
    assign output_in_window_flag_out = 1'b0;
    assign output_in_window_flag_oe = win_low_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_valley_hold;
        (ls_on_reg && valley_s && !neg_rise && !hs_on_reg) |=> !hs_on_reg;
    endproperty
    a_valley_hold: assert property (p_valley_hold) else $error("pulse during valley limit");

    property p_under_latch;
        (state_reg == ST_RUN && under_s && !trig &&
         under_cnt_reg == 16'(UNDER_CYC - 1)) |=> state_reg == ST_LATCHED;
    endproperty
    a_under_latch: assert property (p_under_latch) else $error("no latch after delay");

    property p_under_gated;
        (state_reg != ST_RUN) |=> under_cnt_reg == 16'h0000;
    endproperty
    a_under_gated: assert property (p_under_gated) else $error("timer ran before run");

    property p_under_clear;
        (state_reg == ST_RUN && !under_s) |=> under_cnt_reg == 16'h0000;
    endproperty
    a_under_clear: assert property (p_under_clear) else $error("timer not cleared");

    sequence s_latched_quiet;
        (state_reg == ST_LATCHED && !trig) [*2];
    endsequence
    property p_latched_off;
        s_latched_quiet |-> !hs_on_reg && !ls_on_reg && state_reg == ST_LATCHED;
    endproperty
    a_latched_off: assert property (p_latched_off) else $error("switch on while latched");

    property p_ss_limit;
        (state_reg == ST_SOFTSTART && ocl_seen_reg && !trig && sync_reg[`IN_SS_DONE])
            |=> state_reg == ST_LATCHED;
    endproperty
    a_ss_limit: assert property (p_ss_limit) else $error("start-up limit not latched");

    sequence s_neg_hit;
        active && ls_on_reg && !hs_on_reg && neg_rise && !trig;
    endsequence
    property p_neg_pulse;
        s_neg_hit |=> hs_on_reg && !ls_on_reg;
    endproperty
    a_neg_pulse: assert property (p_neg_pulse) else $error("no pulse on negative limit");

    property p_win_high;
        !win_low_reg |-> $past(state_reg == ST_RUN && !win_latch_reg);
    endproperty
    a_win_high: assert property (p_win_high) else $error("flag high outside run");

    property p_win_latch;
        (win_bad && !win_latch_reg && en_s && sync_reg[`IN_VCC_OK] &&
         win_cnt_reg == 16'(WIN_CYC - 1)) |=> win_latch_reg ##1 win_low_reg;
    endproperty
    a_win_latch: assert property (p_win_latch) else $error("flag not latched low");

    property p_win_stay;
        (win_latch_reg && en_s && sync_reg[`IN_VCC_OK]) |=> win_latch_reg;
    endproperty
    a_win_stay: assert property (p_win_stay) else $error("flag latch released");

    property p_over_hs;
        (over_latch_reg && active && !hs_on_reg && !neg_rise) |=> !hs_on_reg;
    endproperty
    a_over_hs: assert property (p_over_hs) else $error("high side on in overvoltage");

    property p_discharge_off;
        discharge_on_reg |-> !hs_on_reg && !ls_on_reg;
    endproperty
    a_discharge_off: assert property (p_discharge_off) else $error("switch on in discharge");

    property p_enter_dis;
        (state_reg != ST_OFF && trig) |=> state_reg == ST_DISCHARGE;
    endproperty
    a_enter_dis: assert property (p_enter_dis) else $error("discharge not entered");

    property p_dis_hold;
        (state_reg == ST_DISCHARGE && dis_cnt_reg < 16'(DIS_HOLD_CYC - 1))
            |=> state_reg == ST_DISCHARGE;
    endproperty
    a_dis_hold: assert property (p_dis_hold) else $error("discharge left early");

    property p_mode_frozen;
        cal_done_reg |=> $stable(skip_mode_reg) && $stable(freq_sel_reg);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed after window");
endmodule : buck_fault_protection_sequencer

// >>> buck_seq_consts.svh
// constants for the converter protection and mode sequencer
`ifndef BUCK_SEQ_CONSTS_SVH
`define BUCK_SEQ_CONSTS_SVH
`define CLK_FREQ_MHZ 50
`define UNDER_DELAY_US 64
`define UNDER_DELAY_CYC (`UNDER_DELAY_US * `CLK_FREQ_MHZ)
`define WIN_DELAY_US 5
`define WIN_DELAY_CYC (`WIN_DELAY_US * `CLK_FREQ_MHZ)
`define DIS_HOLD_US 128
`define DIS_HOLD_CYC (`DIS_HOLD_US * `CLK_FREQ_MHZ)
`define CAL_TIME_US 20
`define CAL_CYC (`CAL_TIME_US * `CLK_FREQ_MHZ)
`define ZERO_ENTRY_COUNT 16
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CONFIG 8'h08
`define CTRL_EN_BIT 0
`define CTRL_EN_RESET 1'b1
`define IN_EN 0
`define IN_VCC_OK 1
`define IN_VIN_OK 2
`define IN_OVER_TEMP 3
`define IN_UNDER 4
`define IN_OVER 5
`define IN_SOFT_OVER 6
`define IN_BELOW_100MV 7
`define IN_VALLEY 8
`define IN_NEG 9
`define IN_ZERO 10
`define IN_SS_DONE 11
`define IN_PREBIAS 12
`define IN_ONTIME 13
`define IN_HS_REQ 14
`define IN_LIMIT_LOW 15
`define IN_MODE_SKIP 16
`define IN_FREQ_LSB 17
`define IN_COUNT 19
`endif

// >>> buck_seq_pkg.sv
// types shared by the converter protection and mode sequencer
package buck_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_DISCHARGE,
        ST_SOFTSTART,
        ST_RUN,
        ST_LATCHED
    } seq_state_t;
endpackage : buck_seq_pkg

// >>> buck_fault_protection_sequencer_tb_top.sv
// self-checking bench for the converter protection and mode sequencer
`timescale 1ns/1ps
module buck_fault_protection_sequencer_tb_top;
    import buck_seq_pkg::*;
    logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, hs_en, ls_en, dis_on, ss_dis, reg_on, clamp, light, fl_out, fl_oe;
    logic [1:0] freq, fsel = 2'h2;
    logic en = 0, vcc = 0, vin = 0, ot = 0, uv = 0, ov = 0, sov = 0, b100 = 0, valley = 0;
    logic neg = 0, zc = 0, ssc = 0, preb = 0, ont = 0, hreq = 0, lim = 1, skip = 1;
    int failures = 0, n_tests = 0;

    buck_fault_protection_sequencer #(.DIS_HOLD_CYC(20), .CAL_CYC(8)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enable_pin(en), .vcc_ok(vcc), .vin_ok(vin), .over_temp(ot),
        .undervoltage_guard_hit(uv), .overvoltage_guard_hit(ov),
        .soft_overvoltage_clamp_hit(sov), .feedback_sense_below_100mv(b100),
        .valley_current_limit_hit(valley), .negative_current_limit_hit(neg),
        .zero_cross_threshold_hit(zc), .ss_complete(ssc), .prebias_above_command(preb),
        .ontime_done(ont), .hs_request(hreq), .limit_set_pin_low(lim), .mode_skip_sel(skip),
        .mode_freq_sel(fsel), .hs_enable(hs_en), .ls_enable(ls_en), .discharge_on(dis_on),
        .ss_discharge(ss_dis), .regulator_on(reg_on), .fixed_clamp_sel(clamp),
        .light_load_mode(light), .freq_sel(freq), .output_in_window_flag_out(fl_out),
        .output_in_window_flag_oe(fl_oe));

    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // a trailing edge after release keeps psel from being assigned twice in one step
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int i;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
        if (i == 20)
        begin
            failures++;
            summarize();
        end
    endtask : apb

    task automatic wait_state(logic [2:0] s);
        for (int i = 0; i < 300; i++)
        begin
            apb(0, 8'h04, 0);
            if (rd[2:0] === s)
                return;
        end
        chk("state wait", rd[2:0], s);
        summarize();
    endtask : wait_state

    task automatic t_regs();
        apb(0, 8'h00, 0);
        chk("ctrl", rd, 32'h1);
        apb(1, 8'h10, 32'hFFFFFFFF);
        chk("unmapped err", err, 1);
        apb(0, 8'h10, 0);
        chk("unmapped data", rd, 0);
        skip <= 0;
        fsel <= 2'h1;
        tick(6);
        apb(0, 8'h08, 0);
        chk("config", rd, 32'h1D);
        chk("freq", freq, 2'h2);
        chk("clamp", clamp, 1);
        $display("test regs done");
    endtask : t_regs

    task automatic t_start();
        en <= 1;
        vcc <= 1;
        vin <= 1;
        uv <= 1;
        wait_state(3'h2);
        chk("ss node", ss_dis, 0);
        tick(400);
        apb(0, 8'h04, 0);
        chk("uv idle", rd[2:0], 3'h2);
        chk("flag in start", fl_oe, 1);
        uv <= 0;
        ssc <= 1;
        wait_state(3'h3);
        tick(4);
        chk("flag up", fl_oe, 0);
        chk("flag level", fl_out, 0);
        // one period first, so the low side conducts when the valley limit appears
        hreq <= 1;
        tick(4);
        hreq <= 0;
        ont <= 1;
        tick(4);
        ont <= 0;
        valley <= 1;
        tick(4);
        hreq <= 1;
        tick(6);
        chk("valley hs", hs_en, 0);
        chk("valley ls", ls_en, 1);
        valley <= 0;
        hreq <= 0;
        tick(4);
        // each period: pulse, on-time end, then a zero cross in the low phase
        for (int k = 1; k <= 16; k++)
        begin
            hreq <= 1;
            tick(4);
            hreq <= 0;
            ont <= 1;
            tick(4);
            ont <= 0;
            zc <= 1;
            tick(4);
            zc <= 0;
            chk("zero cross ls", ls_en, 0);
            chk("light load", light, k == 16);
        end
        sov <= 1;
        tick(4);
        chk("clamp ls", ls_en, 1);
        chk("clamp light", light, 0);
        sov <= 0;
        neg <= 1;
        tick(4);
        chk("neg hs", hs_en, 1);
        chk("neg ls", ls_en, 0);
        neg <= 0;
        ont <= 1;
        tick(4);
        ont <= 0;
        chk("neg relow", ls_en, 1);
        $display("test start done");
    endtask : t_start

    task automatic t_under();
        uv <= 1;
        tick(3000);
        uv <= 0;
        tick(6);
        apb(0, 8'h04, 0);
        chk("short uv", rd[2:0], 3'h3);
        chk("flag latch", fl_oe, 1);
        uv <= 1;
        tick(3100);
        apb(0, 8'h04, 0);
        chk("uv restart", rd[2:0], 3'h3);
        tick(150);
        apb(0, 8'h04, 0);
        chk("uv latch", rd[2:0], 3'h4);
        chk("latched sw", {hs_en, ls_en}, 2'b00);
        uv <= 0;
        tick(50);
        apb(0, 8'h04, 0);
        chk("latch holds", rd[2:0], 3'h4);
        chk("flag held", fl_oe, 1);
        $display("test under done");
    endtask : t_under

    task automatic t_dis();
        en <= 0;
        ssc <= 0;
        tick(6);
        chk("discharge", dis_on, 1);
        chk("sw off", {hs_en, ls_en}, 2'b00);
        b100 <= 1;
        tick(6);
        chk("cut discharge", dis_on, 0);
        chk("cut regulator", reg_on, 0);
        b100 <= 0;
        en <= 1;
        tick(10);
        apb(0, 8'h04, 0);
        chk("hold", rd[2:0], 3'h1);
        wait_state(3'h2);
        for (int k = 0; k < 3; k++)
        begin
            ssc <= 1;
            wait_state(3'h3);
            ot <= (k == 0);
            vcc <= (k != 1);
            vin <= (k != 2);
            tick(6);
            chk("trig discharge", dis_on, 1);
            chk("stop sw", hs_en | ls_en, 0);
            chk("ss discharge", ss_dis, 1);
            ssc <= 0;
            ot <= 0;
            vcc <= 1;
            vin <= 1;
            wait_state(3'h2);
            chk("restart", rd[2:0], 3'h2);
        end
        $display("test discharge done");
    endtask : t_dis

    initial
    begin
        tick(16);
        reset_n <= 1;
        tick(20);
        t_regs();
        t_start();
        t_under();
        t_dis();
        summarize();
    end

    initial
    begin
        tick(100000);
        failures++;
        summarize();
    end
endmodule : buck_fault_protection_sequencer_tb_top
